// ===== logic/sofs_pkg.sv
// Shared constants and carrier types for the section-overhead framer and scrambler.
// Assumes one 100 MHz clock, four byte-wide streams and an AXI4-Lite register bus.
package sofs_pkg;

	// Stream count and counter width.
	localparam int NSTR  = 4;
	localparam int CNT_W = 16;

	// Byte positions inside one STS-12 frame of 9 rows by 1080 bytes.
	localparam logic [13:0] POS_FIRST    = 14'h0000;
	localparam logic [13:0] POS_LAST     = 14'h25F7;
	localparam logic [13:0] POS_A1_LAST  = 14'h000B;
	localparam logic [13:0] POS_A2_FIRST = 14'h000C;
	localparam logic [13:0] POS_J0       = 14'h0018;
	localparam logic [13:0] POS_SPE      = 14'h0024;
	localparam logic [13:0] POS_B1       = 14'h0438;
	localparam logic [13:0] POS_B1_ZLAST = 14'h0443;

	// Framing pattern, scrambler seed and idle fill.
	localparam logic [7:0] A1_VALUE = 8'hF6;
	localparam logic [7:0] A2_VALUE = 8'h28;
	localparam logic [6:0] SCR_SEED = 7'h7F;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_STREAM_EN   = 6'h00;
	localparam logic [5:0] IDX_SCR_CTRL    = 6'h01;
	localparam logic [5:0] IDX_A1A2_ARM    = 6'h02;
	localparam logic [5:0] IDX_A1A2_VALUE  = 6'h03;
	localparam logic [5:0] IDX_A1A2_FRAMES = 6'h04;
	localparam logic [5:0] IDX_B1_FAULT_EN = 6'h05;
	localparam logic [5:0] IDX_AIS_CTRL    = 6'h06;
	localparam logic [5:0] IDX_RX_STATUS   = 6'h07;
	localparam logic [5:0] IDX_FRAME_ERR0  = 6'h08;
	localparam logic [5:0] IDX_B1_INV_MASK = 6'h0F;
	localparam logic [5:0] IDX_B1_ERR0     = 6'h10;

	// Field positions inside the registers.
	localparam int SCR_TX_DIS_BIT = 0;
	localparam int SCR_RX_DIS_BIT = 1;
	localparam int A2_VALUE_LSB   = 8;
	localparam int AIS_OOF_LSB    = 4;
	localparam int STAT_ERRD_LSB  = 4;

	// Reset values and bus answers.
	localparam logic [3:0] RST_STREAM_EN = 4'hF;
	localparam logic [7:0] RST_B1_MASK   = 8'h00;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	// Receive framer states.
	typedef enum logic [1:0] {
		RX_HUNT,
		RX_SYNC,
		RX_ERRORED
	} sofs_rx_state_t;

	// Master-driven AXI4-Lite signals.
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} sofs_axi_req_t;

	// Slave-driven AXI4-Lite signals.
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sofs_axi_rsp_t;

	// One transmit lane towards the serial link core.
	typedef struct packed {
		logic [7:0] data;
		logic       pwrdn;
	} sofs_tx_lane_t;

	// One receive lane towards the fabric.
	typedef struct packed {
		logic [7:0] data;
		logic       parity;
		logic       sync;
	} sofs_rx_lane_t;

endpackage

// ===== logic/sofs_scr.sv
// Byte-wise frame-synchronous scrambler key generator, 1 + x^6 + x^7.
// Assumes the caller raises load on the byte that starts the sequence and step on later bytes.
module sofs_scr (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       load,
	input  wire logic       step,
	output logic [7:0]      key
);
	import sofs_pkg::*;

	typedef struct packed {
		logic [6:0] lfsr;
	} sofs_scr_state_t;

	sofs_scr_state_t s_q;
	sofs_scr_state_t s_d;

	// Produces eight key bits, first bit in the MSB, and the state for the next byte.
	always_comb begin
		logic [6:0] cur;
		cur = load ? SCR_SEED : s_q.lfsr;
		s_d = s_q;
		key = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			key[b] = cur[6];
			cur    = {cur[5:0], cur[6] ^ cur[5]};
		end
		if (load || step) begin
			s_d.lfsr = cur;
		end
	end

	// Registers the generator state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.lfsr <= SCR_SEED;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ===== logic/sofs_top.sv
// Four-stream section-overhead framer: transmit framing, B1, scrambling; receive framer,
// B1 check, descrambling, alarm fill and parity. Registers sit behind AXI4-Lite.
// Assumes fabric inputs share aclk and link bytes arrive from outside, so they are resynchronised.
//
// Implementation choice: the AXI4-Lite register port.
import sofs_pkg::*;

module sofs_top #(
	parameter int unsigned STREAMS = NSTR
) (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire sofs_pkg::sofs_axi_req_t  axi_req,
	output sofs_pkg::sofs_axi_rsp_t       axi_rsp,
	input  wire logic                     transmit_side_frame_strobe,
	input  wire logic                     receive_side_frame_strobe,
	input  wire logic [NSTR-1:0][7:0]     tx_fabric_data,
	output sofs_pkg::sofs_tx_lane_t [NSTR-1:0] tx_lane,
	input  wire logic [NSTR-1:0][7:0]     rx_link_data,
	output sofs_pkg::sofs_rx_lane_t [NSTR-1:0] rx_lane,
	output logic                          rx_system_frame,
	output logic [NSTR-1:0]               oof_event,
	output logic [NSTR-1:0]               frame_err_event
);
	import sofs_pkg::*;

	// The per-stream logic is unrolled for the fixed stream count only.
	if (STREAMS != NSTR) begin : g_bad_streams
		$error("sofs_top supports exactly the package stream count");
	end

	// Software-visible settings.
	typedef struct packed {
		logic [NSTR-1:0] en;
		logic            tx_scr_dis;
		logic            rx_scr_dis;
		logic [NSTR-1:0] arm;
		logic [7:0]      a1_sub;
		logic [7:0]      a2_sub;
		logic [7:0]      frames;
		logic [NSTR-1:0] b1_fault;
		logic [NSTR-1:0] ais_force;
		logic [NSTR-1:0] ais_oof;
		logic [7:0]      b1_mask;
	} sofs_regs_t;

	// Transmit stream state.
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] prev;
		logic       arm_seen;
		logic       burst;
		logic [7:0] left;
	} sofs_txs_t;

	// Receive stream state.
	typedef struct packed {
		logic [7:0]       s1;
		logic [7:0]       s2;
		logic [7:0]       h1;
		logic [7:0]       h2;
		logic [2:0]       ofs;
		sofs_rx_state_t   st;
		logic [13:0]      pos;
		logic [7:0]       acc;
		logic [7:0]       prev;
		logic             started;
		logic             bip_ok;
		logic [CNT_W-1:0] ferr;
		logic [CNT_W-1:0] b1err;
	} sofs_rxs_t;

	// Whole state of the block.
	typedef struct packed {
		sofs_axi_rsp_t                 rsp;
		logic                          aw_have;
		logic                          w_have;
		logic [7:0]                    awaddr;
		logic [31:0]                   wdata;
		logic [3:0]                    wstrb;
		sofs_regs_t                    regs;
		logic [13:0]                   tx_pos;
		sofs_txs_t [NSTR-1:0]          txs;
		sofs_rxs_t [NSTR-1:0]          rxs;
		sofs_tx_lane_t [NSTR-1:0]      tx_out;
		sofs_rx_lane_t [NSTR-1:0]      rx_out;
		logic [NSTR-1:0]               oof_ev;
		logic [NSTR-1:0]               ferr_ev;
		logic                          rx_sys;
	} sofs_state_t;

	sofs_state_t s_q;
	sofs_state_t s_d;

	logic [13:0]           tx_cur_pos;
	logic [NSTR-1:0][7:0]  tx_key;
	logic [NSTR-1:0][7:0]  rx_key;
	logic [NSTR-1:0]       rx_locked;

	// Counts the set bits of a byte.
	function automatic logic [3:0] ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	// Returns the register word at an index, with a flag that the index is mapped.
	function automatic logic [32:0] rd_word(input sofs_state_t st, input logic [5:0] idx);
		logic [31:0] w;
		logic        ok;
		w  = 32'h0000_0000;
		ok = 1'b1;
		unique case (idx)
			IDX_STREAM_EN:   w[NSTR-1:0] = st.regs.en;
			IDX_SCR_CTRL: begin
				w[SCR_TX_DIS_BIT] = st.regs.tx_scr_dis;
				w[SCR_RX_DIS_BIT] = st.regs.rx_scr_dis;
			end
			IDX_A1A2_ARM:    w[NSTR-1:0] = st.regs.arm;
			IDX_A1A2_VALUE:  w[15:0] = {st.regs.a2_sub, st.regs.a1_sub};
			IDX_A1A2_FRAMES: w[7:0] = st.regs.frames;
			IDX_B1_FAULT_EN: w[NSTR-1:0] = st.regs.b1_fault;
			IDX_AIS_CTRL:    w[7:0] = {st.regs.ais_oof, st.regs.ais_force};
			IDX_B1_INV_MASK: w[7:0] = st.regs.b1_mask;
			IDX_RX_STATUS: begin
				for (int i = 0; i < NSTR; i++) begin
					w[i] = (st.rxs[i].st == RX_HUNT);
					w[STAT_ERRD_LSB + i] = (st.rxs[i].st == RX_ERRORED);
				end
			end
			default: begin
				ok = 1'b0;
				for (int i = 0; i < NSTR; i++) begin
					if (idx == IDX_FRAME_ERR0 + 6'(i)) begin
						w[CNT_W-1:0] = st.rxs[i].ferr;
						ok = 1'b1;
					end
					if (idx == IDX_B1_ERR0 + 6'(i)) begin
						w[CNT_W-1:0] = st.rxs[i].b1err;
						ok = 1'b1;
					end
				end
			end
		endcase
		return {ok, w};
	endfunction

	// Transmit byte position, restarted so that the strobe byte is the first A1.
	assign tx_cur_pos = transmit_side_frame_strobe ? POS_FIRST : s_q.tx_pos;

	// Scrambler key generators, one pair per stream.
	for (genvar g = 0; g < NSTR; g++) begin : g_scr
		assign rx_locked[g] = (s_q.rxs[g].st != RX_HUNT);

		sofs_scr u_tx_scr (
			.aclk    (aclk),
			.aresetn (aresetn),
			.load    (tx_cur_pos == POS_SPE),
			.step    (tx_cur_pos > POS_SPE),
			.key     (tx_key[g])
		);

		sofs_scr u_rx_scr (
			.aclk    (aclk),
			.aresetn (aresetn),
			.load    (rx_locked[g] && s_q.rxs[g].pos == POS_SPE),
			.step    (rx_locked[g] && s_q.rxs[g].pos > POS_SPE),
			.key     (rx_key[g])
		);
	end

	// Next-state logic for the bus slave, the transmit path and the receive path.
	always_comb begin
		logic [32:0] rd;
		logic [31:0] bm;
		logic [31:0] mw;
		logic [23:0] win;
		logic [7:0]  b;
		logic [7:0]  o;
		logic [7:0]  cur;
		logic [7:0]  prv;
		logic [7:0]  desc;
		logic        hit;
		rd   = 33'h0_0000_0000;
		bm   = 32'h0000_0000;
		mw   = 32'h0000_0000;
		win  = 24'h00_0000;
		b    = 8'h00;
		o    = 8'h00;
		cur  = 8'h00;
		prv  = 8'h00;
		desc = 8'h00;
		hit  = 1'b0;
		s_d  = s_q;

		// Bus: retire answers, capture address and data in either order.
		if (s_q.rsp.bvalid && axi_req.bready) begin
			s_d.rsp.bvalid = 1'b0;
		end
		if (s_q.rsp.rvalid && axi_req.rready) begin
			s_d.rsp.rvalid = 1'b0;
		end
		if (axi_req.awvalid && s_q.rsp.awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_q.rsp.wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = axi_req.wdata;
			s_d.wstrb  = axi_req.wstrb;
		end

		// Bus: perform a held write with byte lanes; unmapped or read-only words answer.
		if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid) begin
			rd = rd_word(s_q, s_q.awaddr[7:2]);
			for (int l = 0; l < 4; l++) begin
				bm[l*8 +: 8] = {8{s_q.wstrb[l]}};
			end
			mw = (rd[31:0] & ~bm) | (s_q.wdata & bm);
			unique case (s_q.awaddr[7:2])
				IDX_STREAM_EN:   s_d.regs.en = mw[NSTR-1:0];
				IDX_SCR_CTRL: begin
					s_d.regs.tx_scr_dis = mw[SCR_TX_DIS_BIT];
					s_d.regs.rx_scr_dis = mw[SCR_RX_DIS_BIT];
				end
				IDX_A1A2_ARM:    s_d.regs.arm = mw[NSTR-1:0];
				IDX_A1A2_VALUE: begin
					s_d.regs.a1_sub = mw[7:0];
					s_d.regs.a2_sub = mw[A2_VALUE_LSB +: 8];
				end
				IDX_A1A2_FRAMES: s_d.regs.frames = mw[7:0];
				IDX_B1_FAULT_EN: s_d.regs.b1_fault = mw[NSTR-1:0];
				IDX_AIS_CTRL: begin
					s_d.regs.ais_force = mw[NSTR-1:0];
					s_d.regs.ais_oof   = mw[AIS_OOF_LSB +: NSTR];
				end
				IDX_B1_INV_MASK: s_d.regs.b1_mask = mw[7:0];
				default: ;
			endcase
			s_d.aw_have    = 1'b0;
			s_d.w_have     = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end

		// Bus: answer a read in the cycle after it is taken.
		if (axi_req.arvalid && s_q.rsp.arready) begin
			rd = rd_word(s_q, axi_req.araddr[7:2]);
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata  = rd[31:0];
			s_d.rsp.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.rsp.awready = !s_d.aw_have;
		s_d.rsp.wready  = !s_d.w_have;
		s_d.rsp.arready = !s_d.rsp.rvalid;

		// Transmit position counter, shared by all streams.
		s_d.tx_pos = (tx_cur_pos == POS_LAST) ? POS_FIRST : tx_cur_pos + 14'h0001;
		s_d.rx_sys = receive_side_frame_strobe;

		// Transmit streams: overhead insertion, disable, scrambling and parity.
		for (int i = 0; i < NSTR; i++) begin
			b = tx_fabric_data[i];
			if (tx_cur_pos <= POS_A1_LAST) begin
				b = (s_q.txs[i].burst && tx_cur_pos == POS_A1_LAST) ?
					s_q.regs.a1_sub : A1_VALUE;
			end else if (tx_cur_pos < POS_J0) begin
				b = (s_q.txs[i].burst && tx_cur_pos == POS_A2_FIRST) ?
					s_q.regs.a2_sub : A2_VALUE;
			end else if (tx_cur_pos == POS_B1) begin
				b = s_q.txs[i].prev ^ (s_q.regs.b1_fault[i] ? s_q.regs.b1_mask : 8'h00);
			end else if (tx_cur_pos > POS_B1 && tx_cur_pos <= POS_B1_ZLAST) begin
				b = 8'h00;
			end
			if (!s_q.regs.en[i]) begin
				b = ALL_ONES;
			end
			o = (tx_cur_pos < POS_SPE || s_q.regs.tx_scr_dis) ? b : b ^ tx_key[i];
			s_d.tx_out[i].data  = o;
			s_d.tx_out[i].pwrdn = !s_q.regs.en[i];

			// Parity over the scrambled frame, handed to the next frame's B1.
			if (tx_cur_pos == POS_LAST) begin
				s_d.txs[i].prev = s_q.txs[i].acc ^ o;
				s_d.txs[i].acc  = 8'h00;
			end else begin
				s_d.txs[i].acc = s_q.txs[i].acc ^ o;
			end

			// Corruption burst: starts at a frame boundary, counted in whole frames.
			if (!s_q.regs.arm[i]) begin
				s_d.txs[i].burst    = 1'b0;
				s_d.txs[i].arm_seen = 1'b0;
			end else if (tx_cur_pos == POS_LAST) begin
				if (s_q.txs[i].burst) begin
					if (s_q.regs.frames != 8'h00) begin
						s_d.txs[i].left = s_q.txs[i].left - 8'h01;
						if (s_q.txs[i].left <= 8'h01) begin
							s_d.txs[i].burst = 1'b0;
						end
					end
				end else if (!s_q.txs[i].arm_seen) begin
					s_d.txs[i].arm_seen = 1'b1;
					s_d.txs[i].burst    = 1'b1;
					s_d.txs[i].left     = s_q.regs.frames;
				end
			end
		end

		// Receive streams: resynchronise, frame, check, descramble and fill.
		for (int i = 0; i < NSTR; i++) begin
			s_d.rxs[i].s1 = rx_link_data[i];
			s_d.rxs[i].s2 = s_q.rxs[i].s1;
			s_d.rxs[i].h1 = s_q.rxs[i].s2;
			s_d.rxs[i].h2 = s_q.rxs[i].h1;
			win = {s_q.rxs[i].h2, s_q.rxs[i].h1, s_q.rxs[i].s2};
			cur = win[8 - int'(s_q.rxs[i].ofs) +: 8];
			prv = win[16 - int'(s_q.rxs[i].ofs) +: 8];
			hit = (prv == A1_VALUE) && (cur == A2_VALUE);
			s_d.oof_ev[i]  = 1'b0;
			s_d.ferr_ev[i] = 1'b0;
			s_d.rxs[i].pos = (s_q.rxs[i].pos == POS_LAST) ? POS_FIRST :
				s_q.rxs[i].pos + 14'h0001;

			// Framer: hunt every bit offset, then check the A1/A2 transition each frame.
			unique case (s_q.rxs[i].st)
				RX_HUNT: begin
					for (int k = 7; k >= 0; k--) begin
						if (win[16 - k +: 8] == A1_VALUE && win[8 - k +: 8] == A2_VALUE) begin
							s_d.rxs[i].ofs = 3'(k);
							s_d.rxs[i].st  = RX_SYNC;
							s_d.rxs[i].pos = POS_A2_FIRST + 14'h0001;
						end
					end
					s_d.rxs[i].started = 1'b0;
					s_d.rxs[i].bip_ok  = 1'b0;
				end
				RX_SYNC: begin
					if (s_q.rxs[i].pos == POS_A2_FIRST && !hit) begin
						s_d.rxs[i].st   = RX_ERRORED;
						s_d.rxs[i].ferr = s_q.rxs[i].ferr + CNT_W'(1);
						s_d.ferr_ev[i]  = 1'b1;
					end
				end
				RX_ERRORED: begin
					if (s_q.rxs[i].pos == POS_A2_FIRST) begin
						if (hit) begin
							s_d.rxs[i].st = RX_SYNC;
						end else begin
							s_d.rxs[i].st   = RX_HUNT;
							s_d.rxs[i].ferr = s_q.rxs[i].ferr + CNT_W'(1);
							s_d.ferr_ev[i]  = 1'b1;
							s_d.oof_ev[i]   = 1'b1;
						end
					end
				end
			endcase

			// Descramble outside the unscrambled overhead, then check B1.
			desc = (s_q.rxs[i].pos < POS_SPE || s_q.regs.rx_scr_dis || !rx_locked[i]) ?
				cur : cur ^ rx_key[i];
			if (rx_locked[i]) begin
				if (s_q.rxs[i].pos == POS_FIRST) begin
					s_d.rxs[i].started = 1'b1;
				end
				if (s_q.rxs[i].pos == POS_LAST) begin
					s_d.rxs[i].prev   = s_q.rxs[i].acc ^ cur;
					s_d.rxs[i].acc    = 8'h00;
					s_d.rxs[i].bip_ok = s_q.rxs[i].started;
				end else begin
					s_d.rxs[i].acc = s_q.rxs[i].acc ^ cur;
				end
				if (s_q.rxs[i].pos == POS_B1 && s_q.rxs[i].bip_ok) begin
					s_d.rxs[i].b1err = s_q.rxs[i].b1err +
						CNT_W'(ones8(desc ^ s_q.rxs[i].prev));
				end
			end

			// Alarm fill, parity and frame sync towards the fabric.
			if (s_q.regs.ais_force[i] || (s_q.regs.ais_oof[i] && !rx_locked[i])) begin
				desc = ALL_ONES;
			end
			s_d.rx_out[i].data   = desc;
			s_d.rx_out[i].parity = ^desc;
			s_d.rx_out[i].sync   = rx_locked[i] && (s_q.rxs[i].pos == POS_FIRST);
		end
	end

	// Registers the whole state; settings take their reset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q              <= '0;
			s_q.regs.en      <= RST_STREAM_EN;
			s_q.regs.b1_mask <= RST_B1_MASK;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output comes straight from the state register.
	assign axi_rsp         = s_q.rsp;
	assign tx_lane         = s_q.tx_out;
	assign rx_lane         = s_q.rx_out;
	assign rx_system_frame = s_q.rx_sys;
	assign oof_event       = s_q.oof_ev;
	assign frame_err_event = s_q.ferr_ev;
endmodule

// ===== sim/sofs_far_model.sv
// Far side of the framer: fabric strobes and data, plus the link looped back per stream.
// Assumes one shared clock; the link returns each sent byte one cycle later, byte aligned.
module sofs_far_model
	import sofs_pkg::*;
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire sofs_pkg::sofs_tx_lane_t [NSTR-1:0] tx_lane,
	output logic                               transmit_side_frame_strobe,
	output logic                               receive_side_frame_strobe,
	output logic [NSTR-1:0][7:0]               tx_fabric_data,
	output logic [NSTR-1:0][7:0]               rx_link_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] pos_q;
	logic [7:0]  cnt_q;

	// Strobes mark each frame start; fabric bytes count up so gaps are visible.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_q <= 14'h25E4;
			cnt_q <= 8'h00;
			transmit_side_frame_strobe <= 1'b0;
			receive_side_frame_strobe <= 1'b0;
			tx_fabric_data <= '0;
			rx_link_data <= '0;
		end else begin
			pos_q <= (pos_q == POS_LAST) ? POS_FIRST : pos_q + 14'h0001;
			transmit_side_frame_strobe <= (pos_q == POS_LAST);
			receive_side_frame_strobe <= (pos_q == POS_LAST);
			cnt_q <= cnt_q + 8'h01;
			for (int i = 0; i < NSTR; i++) begin
				tx_fabric_data[i] <= cnt_q + 8'(i);
				rx_link_data[i] <= tx_lane[i].data;
			end
		end
	end
endmodule

// ===== sim/sofs_top_monitor.sv
// Checker for the four-stream framer top; it watches the top's ports only.
// Assumes it is bound to the top and that both frame strobes are single-cycle pulses.
module sofs_top_monitor
	import sofs_pkg::*;
(
	input wire logic                         aclk,
	input wire logic                         aresetn,
	input wire sofs_pkg::sofs_axi_req_t      axi_req,
	input wire sofs_pkg::sofs_axi_rsp_t      axi_rsp,
	input wire logic                         transmit_side_frame_strobe,
	input wire logic                         receive_side_frame_strobe,
	input wire logic [NSTR-1:0][7:0]         tx_fabric_data,
	input wire sofs_pkg::sofs_tx_lane_t [NSTR-1:0] tx_lane,
	input wire sofs_pkg::sofs_rx_lane_t [NSTR-1:0] rx_lane,
	input wire logic                         rx_system_frame,
	input wire logic [NSTR-1:0]              oof_event,
	input wire logic [NSTR-1:0]              frame_err_event
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Frame strobes, framing bytes and overhead bypass of stream zero.
	a_rx_frame_echo: assert property (receive_side_frame_strobe |=>
		rx_system_frame ##1 !rx_system_frame) else $error("receive frame echo wrong");
	a_tx_a1_first: assert property (transmit_side_frame_strobe |=>
		tx_lane[0].data == A1_VALUE) else $error("first framing byte wrong");
	a_tx_a2_mid: assert property (transmit_side_frame_strobe |->
		##14 tx_lane[0].data == A2_VALUE) else $error("second framing byte wrong");
	a_j0_bypass: assert property (transmit_side_frame_strobe |->
		##25 tx_lane[0].data == $past(tx_fabric_data[0])) else $error("trace byte altered");

	// Receive side parity, sync spacing and alarm pulses.
	a_rx_parity: assert property (rx_lane[0].parity == ^rx_lane[0].data)
		else $error("receive parity wrong");
	a_sync_gap: assert property ($rose(rx_lane[0].sync) |=> !rx_lane[0].sync [*8])
		else $error("sync pulse too long");
	a_event_pulse: assert property ((oof_event | frame_err_event) != 4'h0 |=>
		((oof_event & $past(oof_event)) | (frame_err_event & $past(frame_err_event))) == 4'h0)
		else $error("event longer than a cycle");
	a_oof_errored: assert property (oof_event != 4'h0 |->
		(oof_event & ~frame_err_event) == 4'h0) else $error("out of frame without errored frame");

	// Register bus answers at the latency the design promises.
	a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
		&& axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write answer late");
endmodule

// ===== sim/testbench.sv
// Top bench: drives registers over AXI4-Lite and checks transmit frames and receive alarms.
// Assumes the far-side model loops each transmit lane back into its receive lane.
module testbench;
	import sofs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	sofs_axi_req_t req = '0;
	sofs_axi_rsp_t rsp;
	logic tstb, rstb, sysf;
	logic [NSTR-1:0] oofe, ferr;
	logic [NSTR-1:0][7:0] fab, lnk;
	sofs_tx_lane_t [NSTR-1:0] txl;
	sofs_rx_lane_t [NSTR-1:0] rxl;
	int miscompares = 0;
	int n_compared = 0;
	logic [7:0] cap [NSTR][1092];
	logic [7:0] bip [NSTR];
	logic [7:0] pbip [NSTR];
	logic [31:0] rd;
	logic [1:0] rr;
	logic [15:0] c0;
	logic [15:0] c1;

	// Clock of 100 MHz.
	always #5 aclk = ~aclk;

	sofs_top u_dut (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp),
		.transmit_side_frame_strobe(tstb), .receive_side_frame_strobe(rstb),
		.tx_fabric_data(fab), .tx_lane(txl), .rx_link_data(lnk), .rx_lane(rxl),
		.rx_system_frame(sysf), .oof_event(oofe), .frame_err_event(ferr));
	sofs_far_model u_far (.aclk, .aresetn, .tx_lane(txl), .transmit_side_frame_strobe(tstb),
		.receive_side_frame_strobe(rstb), .tx_fabric_data(fab), .rx_link_data(lnk));

	// Comparison, verdict and bus helpers.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task hang;
		miscompares++;
		$display("[FAIL] %0t wait ran out", $time);
		print_verdict();
	endtask
	function logic [7:0] ad(input logic [5:0] i);
		return {i, 2'b00};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit b = 0;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		for (int n = 0; n < 50 && !b; n++) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			b = rsp.bvalid;
			rr = rsp.bresp;
		end
		if (!b) hang();
	endtask
	task automatic rg(input logic [7:0] a);
		bit g = 0;
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		for (int n = 0; n < 50 && !g; n++) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				g = 1;
				rd = rsp.rdata;
				rr = rsp.rresp;
			end
		end
		if (!g) hang();
	endtask
	// Steps through one whole frame from its strobe, records its first 1092 bytes and folds every byte into a parity per stream.
	task automatic grab;
		#1;
		for (int n = 0; n < 12000 && !tstb; n++) begin
			@(posedge aclk);
			#1;
		end
		if (!tstb) hang();
		pbip = bip;
		bip = '{default: 8'h00};
		for (int p = 0; p < 9720; p++) begin
			@(posedge aclk);
			#1;
			for (int s = 0; s < NSTR; s++) begin
				bip[s] ^= txl[s].data;
				if (p < 1092) cap[s][p] = txl[s].data;
			end
		end
	endtask

	// Main sequence: registers, transmit frame layout, corruption bursts, receive alarms.
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		req.bready <= 1'b1;
		req.rready <= 1'b1;
		repeat (2) @(posedge aclk);
		rg(ad(IDX_B1_INV_MASK));
		chk(rd, {24'h0, RST_B1_MASK});
		rg(8'hFC);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		wr(ad(IDX_B1_INV_MASK), 32'hFFFF_FFA5);
		chk({30'h0, rr}, {30'h0, RESP_OKAY});
		wr(8'hFC, 32'h0);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		rg(ad(IDX_B1_INV_MASK));
		chk(rd, 32'h0000_00A5);
		wr(ad(IDX_SCR_CTRL), 32'h3);
		wr(ad(IDX_STREAM_EN), 32'h7);
		wr(ad(IDX_B1_FAULT_EN), 32'h2);
		grab();
		for (int p = 0; p < 24; p++) chk(32'(cap[0][p]), 32'(p < 12 ? A1_VALUE : A2_VALUE));
		for (int p = 1081; p < 1092; p++) chk(32'(cap[0][p]), 32'h0);
		chk(32'(cap[3][40]), 32'hFF);
		chk(32'(txl[3].pwrdn), 32'h1);
		chk(32'(8'(cap[1][41] - cap[1][40])), 32'h1);
		grab();
		chk(32'(cap[0][1080]), 32'(pbip[0]));
		chk(32'(cap[1][1080]), 32'(pbip[1] ^ 8'hA5));
		rg(ad(IDX_FRAME_ERR0 + 6'h2));
		c0 = rd[15:0];
		wr(ad(IDX_SCR_CTRL), 32'h0);
		wr(ad(IDX_A1A2_VALUE), 32'h0000_C33C);
		wr(ad(IDX_A1A2_FRAMES), 32'h1);
		wr(ad(IDX_A1A2_ARM), 32'h4);
		grab();
		chk({cap[2][10], cap[2][11], cap[2][12], cap[2][13]}, 32'hF63C_C328);
		chk(32'(cap[0][36] ^ 8'hFE), 32'(8'(cap[0][35] + 8'h01)));
		chk(32'(cap[0][37] ^ 8'h04), 32'(8'(cap[0][35] + 8'h02)));
		chk(32'(8'(cap[0][35] - cap[0][24])), 32'h0000_000B);
		grab();
		chk({16'h0, cap[2][11], cap[2][12]}, 32'h0000_F628);
		rg(ad(IDX_FRAME_ERR0 + 6'h2));
		chk(32'(rd[15:0]), 32'(16'(c0 + 16'h1)));
		rg(ad(IDX_B1_ERR0 + 6'h1));
		c1 = rd[15:0];
		wr(ad(IDX_AIS_CTRL), 32'h42);
		wr(ad(IDX_A1A2_FRAMES), 32'h0);
		wr(ad(IDX_A1A2_ARM), 32'h0);
		wr(ad(IDX_A1A2_ARM), 32'h4);
		chk(32'(rxl[1].data), 32'hFF);
		for (int n = 0; n < 25000 && !oofe[2]; n++) begin
			@(posedge aclk);
			#1;
		end
		if (!oofe[2]) hang();
		rg(ad(IDX_RX_STATUS));
		chk({30'h0, rd[2], rd[0]}, 32'h2);
		chk(32'(rxl[2].data), 32'hFF);
		rg(ad(IDX_B1_ERR0 + 6'h1));
		chk(32'(16'(rd[15:0] - c1)), 32'h0000_0008);
		print_verdict();
	end
endmodule

bind sofs_top sofs_top_monitor u_mon (.aclk, .aresetn, .axi_req, .axi_rsp,
	.transmit_side_frame_strobe, .receive_side_frame_strobe, .tx_fabric_data, .tx_lane,
	.rx_lane, .rx_system_frame, .oof_event, .frame_err_event);
